// ### common/dcs_pkg.sv
// shared constants and types for the debug control and status block
package dcs_pkg;

    // control register layout
    localparam int CTRL_W = 6;
    localparam int CTRL_COMP_DIS = 5;
    localparam int CTRL_MON_MODE = 4;
    localparam int CTRL_RSVD = 3;
    localparam int CTRL_INT_DIS = 2;
    localparam int CTRL_FORCE_REQ = 1;
    localparam int CTRL_FORCE_ACK = 0;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

    // status register layout
    localparam int STAT_W = 13;
    localparam int STAT_REQ_ENTRY = 12;
    localparam int STAT_TFLAG = 4;
    localparam int STAT_HTRANS = 3;
    localparam int STAT_PERMIT = 2;
    localparam int STAT_REQ = 1;
    localparam int STAT_ACK = 0;
    localparam logic STAT_FLAG_RESET = 1'b0;

    // scan chain: data field first (lsb first), then address, then read/write
    localparam int DATA_W = 32;
    localparam int ADDR_W = 5;
    localparam int CHAIN_W = DATA_W + ADDR_W + 1;
    localparam int CHAIN_RW = CHAIN_W - 1;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 5'h01;
    localparam logic [ADDR_W-1:0] ADDR_WP_FIRST = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_WP_LAST = 5'h15;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 5'h00;

    // instruction register
    localparam int IR_W = 4;
    localparam logic [IR_W-1:0] IR_ACCESS = 4'h2;
    localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

    // number of pins passed through the synchroniser
    localparam int PIN_SYNC_W = 4;

    typedef enum logic [3:0] {
        TAP_RESET,
        TAP_IDLE,
        TAP_SEL_DR,
        TAP_CAP_DR,
        TAP_SHIFT_DR,
        TAP_EXIT1_DR,
        TAP_PAUSE_DR,
        TAP_EXIT2_DR,
        TAP_UPD_DR,
        TAP_SEL_IR,
        TAP_CAP_IR,
        TAP_SHIFT_IR,
        TAP_EXIT1_IR,
        TAP_PAUSE_IR,
        TAP_EXIT2_IR,
        TAP_UPD_IR
    } dcs_tap_t;

    typedef struct packed {
        dcs_tap_t tap;
        logic [IR_W-1:0] irShift;
        logic [IR_W-1:0] ir;
        logic [CHAIN_W-1:0] dr;
        logic bypass;
        logic [ADDR_W-1:0] addr;
        logic [CTRL_W-1:0] ctrl;
        logic reqLatch;
        logic reqEntry;
        logic ackPrev;
        logic tckPrev;
        logic tdo;
        logic tdoEn;
        logic mergedReq;
        logic ackOut;
        logic permit;
        logic halt;
        logic abortReq;
    } dcs_state_t;

endpackage

// ### hdl/dcs_sync.sv
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ns

module dcs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } dcs_sync_state_t;

    dcs_sync_state_t s;
    dcs_sync_state_t next_s;

    // stage1 feeds stage2 only; nothing else may look at it
    always_comb begin
        next_s = s;
        next_s.stage1 = asyncIn;
        next_s.stage2 = s.stage1;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign syncOut = s.stage2;

endmodule

// ### hdl/dcs_debug_regs.sv
// debug control and status registers behind a scan port
`timescale 1ns/1ns

// What this block does
// - control register holds comparator disable, monitor select, reserved, int disable, forces.
// - writes and reads of any watchpoint register also reach the control register.
// - control bit 5 suppresses comparator outputs; readable and writable over the scan port.
// - a hit halts into debug when bit 4 clear, aborts when bit 4 set.
// - control bit 2 set forces the interrupt permit output low.
// - interrupt permit is high only when debug acknowledge and interrupt disable are low.
// - latched forced request ORed with external request drives core and output pin.
// - forced request latch only follows control bit 1 in Run-Test/Idle.
// - debug acknowledge output is core acknowledge ORed with control bit 0.
// - status register is thirteen bits; bits 12, 4, 3, 2, 1, 0 defined.
// - status access writes when read/write bit set, reads when clear.
// - status bit 12 flags debug entry caused by the debug request.
// - status bit 4 returns the compressed instruction state flag.
// - status bit 3 returns the current level of HTRANS[1].
// - status bit 2 returns the current interrupt permit level.
// - status bits 1 and 0 return the merged debug request and the debug acknowledge output.
module dcs_debug_regs (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdoEn,
    input wire logic debugRequest,
    input wire logic coreInternalDebugAck,
    input wire logic compressedStateFlag,
    input wire logic htrans1,
    input wire logic wpMatch,
    output logic mergedDebugRequestOut,
    output logic debugAcknowledge,
    output logic coreInterruptPermit,
    output logic breakHalt,
    output logic breakAbort
);

    dcs_pkg::dcs_state_t s;
    dcs_pkg::dcs_state_t next_s;

    logic [dcs_pkg::PIN_SYNC_W-1:0] pinSync;
    logic tckSync;
    logic tmsSync;
    logic tdiSync;
    logic reqSync;

    // tck, tms, tdi and the external request are all foreign to clk_sys
    dcs_sync #(
        .WIDTH(dcs_pkg::PIN_SYNC_W)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .asyncIn({debugRequest, tdi, tms, tck}),
        .syncOut(pinSync)
    );

    assign tckSync = pinSync[0];
    assign tmsSync = pinSync[1];
    assign tdiSync = pinSync[2];
    assign reqSync = pinSync[3];

    function automatic dcs_pkg::dcs_tap_t tapNext(input dcs_pkg::dcs_tap_t cur, input logic m);
        dcs_pkg::dcs_tap_t nxt;
        nxt = cur;
        case (cur)
            dcs_pkg::TAP_RESET: begin
                nxt = m ? dcs_pkg::TAP_RESET : dcs_pkg::TAP_IDLE;
            end
            dcs_pkg::TAP_IDLE: begin
                nxt = m ? dcs_pkg::TAP_SEL_DR : dcs_pkg::TAP_IDLE;
            end
            dcs_pkg::TAP_SEL_DR: begin
                nxt = m ? dcs_pkg::TAP_SEL_IR : dcs_pkg::TAP_CAP_DR;
            end
            dcs_pkg::TAP_CAP_DR: begin
                nxt = m ? dcs_pkg::TAP_EXIT1_DR : dcs_pkg::TAP_SHIFT_DR;
            end
            dcs_pkg::TAP_SHIFT_DR: begin
                nxt = m ? dcs_pkg::TAP_EXIT1_DR : dcs_pkg::TAP_SHIFT_DR;
            end
            dcs_pkg::TAP_EXIT1_DR: begin
                nxt = m ? dcs_pkg::TAP_UPD_DR : dcs_pkg::TAP_PAUSE_DR;
            end
            dcs_pkg::TAP_PAUSE_DR: begin
                nxt = m ? dcs_pkg::TAP_EXIT2_DR : dcs_pkg::TAP_PAUSE_DR;
            end
            dcs_pkg::TAP_EXIT2_DR: begin
                nxt = m ? dcs_pkg::TAP_UPD_DR : dcs_pkg::TAP_SHIFT_DR;
            end
            dcs_pkg::TAP_UPD_DR: begin
                nxt = m ? dcs_pkg::TAP_SEL_DR : dcs_pkg::TAP_IDLE;
            end
            dcs_pkg::TAP_SEL_IR: begin
                nxt = m ? dcs_pkg::TAP_RESET : dcs_pkg::TAP_CAP_IR;
            end
            dcs_pkg::TAP_CAP_IR: begin
                nxt = m ? dcs_pkg::TAP_EXIT1_IR : dcs_pkg::TAP_SHIFT_IR;
            end
            dcs_pkg::TAP_SHIFT_IR: begin
                nxt = m ? dcs_pkg::TAP_EXIT1_IR : dcs_pkg::TAP_SHIFT_IR;
            end
            dcs_pkg::TAP_EXIT1_IR: begin
                nxt = m ? dcs_pkg::TAP_UPD_IR : dcs_pkg::TAP_PAUSE_IR;
            end
            dcs_pkg::TAP_PAUSE_IR: begin
                nxt = m ? dcs_pkg::TAP_EXIT2_IR : dcs_pkg::TAP_PAUSE_IR;
            end
            dcs_pkg::TAP_EXIT2_IR: begin
                nxt = m ? dcs_pkg::TAP_UPD_IR : dcs_pkg::TAP_SHIFT_IR;
            end
            dcs_pkg::TAP_UPD_IR: begin
                nxt = m ? dcs_pkg::TAP_SEL_DR : dcs_pkg::TAP_IDLE;
            end
            default: begin
                nxt = dcs_pkg::TAP_RESET;
            end
        endcase
        return nxt;
    endfunction

    // true for the control register itself and for every watchpoint register
    function automatic logic hitsControl(input logic [dcs_pkg::ADDR_W-1:0] a);
        logic hit;
        hit = 1'b0;
        if (a == dcs_pkg::ADDR_CTRL) begin
            hit = 1'b1;
        end else if (a >= dcs_pkg::ADDR_WP_FIRST && a <= dcs_pkg::ADDR_WP_LAST) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    logic tckRise;
    logic tckFall;
    logic accessSel;
    logic [dcs_pkg::STAT_W-1:0] statusWord;
    logic [dcs_pkg::CTRL_W-1:0] ctrlRead;
    logic [dcs_pkg::DATA_W-1:0] captureData;
    logic [dcs_pkg::ADDR_W-1:0] updAddr;
    logic [dcs_pkg::DATA_W-1:0] updData;
    logic ackRise;
    logic compareLive;

    always_comb begin
        tckRise = tckSync & ~s.tckPrev;
        tckFall = ~tckSync & s.tckPrev;
        accessSel = (s.ir == dcs_pkg::IR_ACCESS);
        updAddr = s.dr[dcs_pkg::CHAIN_RW-1 -: dcs_pkg::ADDR_W];
        updData = s.dr[dcs_pkg::DATA_W-1:0];

        ctrlRead = s.ctrl;
        ctrlRead[dcs_pkg::CTRL_RSVD] = 1'b0;

        statusWord = '0;
        statusWord[dcs_pkg::STAT_REQ_ENTRY] = s.reqEntry;
        statusWord[dcs_pkg::STAT_TFLAG] = compressedStateFlag;
        statusWord[dcs_pkg::STAT_HTRANS] = htrans1;
        statusWord[dcs_pkg::STAT_PERMIT] = s.permit;
        statusWord[dcs_pkg::STAT_REQ] = s.mergedReq;
        statusWord[dcs_pkg::STAT_ACK] = s.ackOut;

        captureData = '0;
        if (hitsControl(s.addr)) begin
            captureData[dcs_pkg::CTRL_W-1:0] = ctrlRead;
        end else if (s.addr == dcs_pkg::ADDR_STAT) begin
            captureData[dcs_pkg::STAT_W-1:0] = statusWord;
        end

        ackRise = coreInternalDebugAck & ~s.ackPrev;
        compareLive = wpMatch & ~s.ctrl[dcs_pkg::CTRL_COMP_DIS];
    end

    always_comb begin
        next_s = s;
        next_s.tckPrev = tckSync;
        next_s.ackPrev = coreInternalDebugAck;

        if (tckRise) begin
            next_s.tap = tapNext(s.tap, tmsSync);
            case (s.tap)
                dcs_pkg::TAP_RESET: begin
                    next_s.ir = dcs_pkg::IR_BYPASS;
                end
                dcs_pkg::TAP_CAP_DR: begin
                    // the read comes from the address named by the previous update
                    next_s.dr = {1'b0, s.addr, captureData};
                    next_s.bypass = 1'b0;
                end
                dcs_pkg::TAP_SHIFT_DR: begin
                    if (accessSel) begin
                        next_s.dr = {tdiSync, s.dr[dcs_pkg::CHAIN_W-1:1]};
                    end else begin
                        next_s.bypass = tdiSync;
                    end
                end
                dcs_pkg::TAP_UPD_DR: begin
                    if (accessSel) begin
                        next_s.addr = updAddr;
                        if (s.dr[dcs_pkg::CHAIN_RW] && hitsControl(updAddr)) begin
                            next_s.ctrl = updData[dcs_pkg::CTRL_W-1:0];
                            next_s.ctrl[dcs_pkg::CTRL_RSVD] = 1'b0;
                        end else if (s.dr[dcs_pkg::CHAIN_RW] && updAddr == dcs_pkg::ADDR_STAT) begin
                            next_s.reqEntry = updData[dcs_pkg::STAT_REQ_ENTRY];
                        end
                    end
                end
                dcs_pkg::TAP_CAP_IR: begin
                    next_s.irShift = dcs_pkg::IR_CAPTURE;
                end
                dcs_pkg::TAP_SHIFT_IR: begin
                    next_s.irShift = {tdiSync, s.irShift[dcs_pkg::IR_W-1:1]};
                end
                dcs_pkg::TAP_UPD_IR: begin
                    next_s.ir = s.irShift;
                end
                default: begin
                    next_s.ir = s.ir;
                end
            endcase
        end

        // tdo moves on the falling edge so the debugger samples it stable
        if (tckFall) begin
            if (s.tap == dcs_pkg::TAP_SHIFT_IR) begin
                next_s.tdo = s.irShift[0];
                next_s.tdoEn = 1'b1;
            end else if (s.tap == dcs_pkg::TAP_SHIFT_DR) begin
                next_s.tdo = accessSel ? s.dr[0] : s.bypass;
                next_s.tdoEn = 1'b1;
            end else begin
                next_s.tdo = 1'b0;
                next_s.tdoEn = 1'b0;
            end
        end

        // the latch holds while the debugger arms several cores, then releases all at once
        if (s.tap == dcs_pkg::TAP_IDLE) begin
            next_s.reqLatch = s.ctrl[dcs_pkg::CTRL_FORCE_REQ];
        end

        next_s.mergedReq = s.reqLatch | reqSync;
        next_s.ackOut = coreInternalDebugAck | s.ctrl[dcs_pkg::CTRL_FORCE_ACK];
        next_s.permit = ~(next_s.ackOut | s.ctrl[dcs_pkg::CTRL_INT_DIS]);

        next_s.halt = compareLive & ~s.ctrl[dcs_pkg::CTRL_MON_MODE];
        next_s.abortReq = compareLive & s.ctrl[dcs_pkg::CTRL_MON_MODE];

        // hardware set wins over a debugger write in the same cycle
        if (ackRise && s.mergedReq) begin
            next_s.reqEntry = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s.tap <= dcs_pkg::TAP_RESET;
            s.irShift <= '0;
            s.ir <= dcs_pkg::IR_BYPASS;
            s.dr <= '0;
            s.bypass <= 1'b0;
            s.addr <= dcs_pkg::ADDR_RESET;
            s.ctrl <= dcs_pkg::CTRL_RESET;
            s.reqLatch <= 1'b0;
            s.reqEntry <= dcs_pkg::STAT_FLAG_RESET;
            s.ackPrev <= 1'b0;
            s.tckPrev <= 1'b0;
            s.tdo <= 1'b0;
            s.tdoEn <= 1'b0;
            s.mergedReq <= 1'b0;
            s.ackOut <= 1'b0;
            s.permit <= 1'b1;
            s.halt <= 1'b0;
            s.abortReq <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign tdo = s.tdo;
    assign tdoEn = s.tdoEn;
    assign mergedDebugRequestOut = s.mergedReq;
    assign debugAcknowledge = s.ackOut;
    assign coreInterruptPermit = s.permit;
    assign breakHalt = s.halt;
    assign breakAbort = s.abortReq;

endmodule

// ### verif/dcs_debug_regs_props.sv
// port assertions for the debug control and status block
`timescale 1ns/1ns
module dcs_debug_regs_props (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdoEn,
    input wire logic debugRequest,
    input wire logic coreInternalDebugAck,
    input wire logic compressedStateFlag,
    input wire logic htrans1,
    input wire logic wpMatch,
    input wire logic mergedDebugRequestOut,
    input wire logic debugAcknowledge,
    input wire logic coreInterruptPermit,
    input wire logic breakHalt,
    input wire logic breakAbort
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    ack_follow_a: assert property (coreInternalDebugAck |=> debugAcknowledge)
        else $error("ack out missed core ack");
    permit_ack_a: assert property (debugAcknowledge[*2] |-> !coreInterruptPermit)
        else $error("permit high while ack out");
    permit_core_a: assert property (coreInternalDebugAck[*3] |-> !coreInterruptPermit)
        else $error("permit high while core ack");
    halt_idle_a: assert property (!wpMatch |=> !breakHalt && !breakAbort)
        else $error("break without comparator hit");
    halt_excl_a: assert property (!(breakHalt && breakAbort))
        else $error("halt and abort together");
    req_merge_a: assert property (debugRequest[*4] |-> ##[0:2] mergedDebugRequestOut)
        else $error("external request not merged");
    tdo_fall_a: assert property ($changed(tdo) |-> !tck)
        else $error("scan output moved with clock high");
    tdoen_fall_a: assert property ($changed(tdoEn) |-> !tck)
        else $error("scan enable moved with clock high");
    cover property (breakHalt);
    cover property (breakAbort);
    cover property ($fell(coreInterruptPermit) && !debugAcknowledge);
    cover property ($rose(mergedDebugRequestOut));
endmodule

// ### verif/dcs_debugger.sv
// scan-port debugger model driving the tap pins
`timescale 1ns/1ns
module dcs_debugger (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    logic [37:0] got;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        got = 38'h0;
    end
    // tck stops low between frames; idle tdi toggles so a stale bit is never trusted
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #40 tck = 1'b1;
        o = tdo;
        #40 tck = 1'b0;
    endtask
    task automatic walk(input logic [7:0] s, input int n);
        logic o;
        for (int i = 0; i < n; i++) begin
            step(s[i], ~tdi, o);
        end
    endtask
    // park leaves the tap in Pause-DR so the request latch stays shut
    task automatic scan(input logic ir, input logic [37:0] v, input logic park);
        int n;
        n = ir ? 4 : 38;
        walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, v[i], got[i]);
        end
        walk(park ? 8'h0b : 8'h01, park ? 5 : 2);
    endtask
endmodule

// ### verif/dcs_debug_regs_test.sv
// self-checking bench for the debug control and status block
`timescale 1ns/1ns
bind dcs_debug_regs dcs_debug_regs_props dcs_debug_regs_props_inst (.clk_sys(clk_sys),
    .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn),
    .debugRequest(debugRequest), .coreInternalDebugAck(coreInternalDebugAck),
    .compressedStateFlag(compressedStateFlag), .htrans1(htrans1), .wpMatch(wpMatch),
    .mergedDebugRequestOut(mergedDebugRequestOut), .debugAcknowledge(debugAcknowledge),
    .coreInterruptPermit(coreInterruptPermit), .breakHalt(breakHalt),
    .breakAbort(breakAbort));
module dcs_debug_regs_test;
    logic clk_sys, rst, tck, tms, tdi, tdo, tdoEn, dbgReq, coreAck, cFlag, htr, wpMatch;
    logic merged, ackOut, permit, halt, abortOut;
    logic [31:0] seed;
    logic [5:0] v, n;
    int num_errors, tests_run;
    int cyc = 0;
    dcs_debug_regs dcs_debug_regs_inst (.clk_sys(clk_sys), .rst(rst), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn), .debugRequest(dbgReq),
        .coreInternalDebugAck(coreAck), .compressedStateFlag(cFlag), .htrans1(htr),
        .wpMatch(wpMatch), .mergedDebugRequestOut(merged), .debugAcknowledge(ackOut),
        .coreInterruptPermit(permit), .breakHalt(halt), .breakAbort(abortOut));
    dcs_debugger dcs_debugger_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [31:0] expStat(input logic [5:0] c);
        logic ak;
        ak = coreAck | c[0];
        return {27'h0, cFlag, htr, ~(ak | c[2]), c[1] | dbgReq, ak};
    endfunction
    task automatic give_verdict();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic scan(input logic [4:0] a, input logic [31:0] d, input logic w,
        input logic park);
        dcs_debugger_inst.scan(1'b0, {w, a, d}, park);
    endtask
    // a read needs a second scan to shift out what the first one addressed
    task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] e);
        scan(a, 32'h0, 1'b0, 1'b0);
        scan(a, 32'h0, 1'b0, 1'b0);
        chk(nm, e, dcs_debugger_inst.got[31:0]);
    endtask
    task automatic prog(input logic [5:0] o, input logic [5:0] nv, input logic [4:0] wa);
        scan(dcs_pkg::ADDR_CTRL, {26'h0, o | 6'h20}, 1'b1, 1'b0);
        scan(wa, {26'h0, nv | 6'h20}, 1'b1, 1'b0);
        scan(dcs_pkg::ADDR_CTRL, {26'h0, nv}, 1'b1, 1'b0);
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        {rst, dbgReq, coreAck, cFlag, htr, wpMatch} = 6'h20;
        num_errors = 0;
        tests_run = 0;
        seed = 32'hdd228d54;
        v = 6'h0;
        repeat (16) @(posedge clk_sys);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk_sys);
        dcs_debugger_inst.walk(8'h00, 1);
        dcs_debugger_inst.scan(1'b1, {34'h0, dcs_pkg::IR_ACCESS}, 1'b0);
        rdc("ctrl reset", dcs_pkg::ADDR_CTRL, 32'h0);
        rdc("status reset", dcs_pkg::ADDR_STAT, 32'h4);
        scan(5'h1f, 32'h3f, 1'b1, 1'b0);
        rdc("unmapped", 5'h1f, 32'h0);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            @(posedge clk_sys);
            #1 {dbgReq, coreAck, cFlag, htr} = seed[3:0];
            wpMatch = seed[4] | (i < 3);
            n = (i == 0) ? 6'h10 : (i == 1) ? 6'h07 : (i == 2) ? 6'h24 : seed[13:8];
            n = n & 6'h37;
            prog(v, n, 5'(8 + seed[19:16] % 14));
            v = n;
            repeat (4) @(posedge clk_sys);
            // look a step after the edge so registered outputs have settled
            #1;
            chk("ack", 32'(coreAck | v[0]), 32'(ackOut));
            // logical not keeps the permit expectation one bit wide inside the cast
            chk("permit", 32'(!(coreAck | v[0] | v[2])), 32'(permit));
            chk("tdo enable idle", 32'h0, 32'(tdoEn));
            chk("merged", 32'(v[1] | dbgReq), 32'(merged));
            chk("halt", 32'(wpMatch & ~v[5] & ~v[4]), 32'(halt));
            chk("abort", 32'(wpMatch & ~v[5] & v[4]), 32'(abortOut));
            rdc("ctrl wp", 5'(8 + seed[23:20] % 14), {26'h0, v});
            scan(dcs_pkg::ADDR_STAT, 32'h0, 1'b1, 1'b0);
            rdc("status", dcs_pkg::ADDR_STAT, expStat(v));
        end
        @(posedge clk_sys);
        #1 {dbgReq, coreAck, cFlag, htr} = 4'h0;
        prog(v, 6'h02, dcs_pkg::ADDR_WP_FIRST);
        scan(dcs_pkg::ADDR_STAT, 32'h0, 1'b1, 1'b0);
        @(posedge clk_sys);
        #1 coreAck = 1'b1;
        rdc("entry flag", dcs_pkg::ADDR_STAT, 32'h1003);
        scan(dcs_pkg::ADDR_STAT, 32'h0, 1'b1, 1'b0);
        rdc("flag cleared", dcs_pkg::ADDR_STAT, 32'h0003);
        prog(6'h02, 6'h00, dcs_pkg::ADDR_WP_LAST);
        scan(dcs_pkg::ADDR_CTRL, 32'h2, 1'b1, 1'b1);
        repeat (8) @(posedge clk_sys);
        #1;
        chk("latch shut", 32'h0, 32'(merged));
        dcs_debugger_inst.walk(8'h03, 3);
        repeat (4) @(posedge clk_sys);
        #1;
        chk("latch open", 32'h1, 32'(merged));
        give_verdict();
    end
endmodule
